// [tb/test_acmp_regs.sv]
/*
  Self-checking testbench for the analog comparator register bank.
  Assumes acmp_pkg and acmp_regs are compiled first and that the params
  header is on the include path.
*/
`timescale 1ns/1ps
`include "acmp_params.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("BAD %s expected %h seen %h", nm, ex, got); fails++; end end
module test_acmp_regs;
  import acmp_pkg::*;

  logic                 mclk;
  logic                 rst_b;
  avl_req_type          avl_req;
  avl_rsp_type          avl_rsp;
  logic [2:0]           cmp_raw;
  ladder_cfg_type       ladder_cfg;
  logic [5:0]           ladder_total;
  logic [3:0]           ladder_tap_eff;
  logic [5:0]           positive_source_select;
  logic                 irq;
  int                   fails;
  int                   check_count;
  logic [31:0]          rd;

  acmp_regs dut_u (
    .mclk                   (mclk),
    .rst_b                  (rst_b),
    .avl_req                (avl_req),
    .avl_rsp                (avl_rsp),
    .cmp_raw                (cmp_raw),
    .ladder_cfg             (ladder_cfg),
    .ladder_total           (ladder_total),
    .ladder_tap_eff         (ladder_tap_eff),
    .positive_source_select (positive_source_select),
    .irq                    (irq)
  );

  // Free-running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // One bus transfer: request held until waitrequest is seen low at an edge.
  task automatic bus_xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rdat);
    int n;
    n = 0;
    avl_req.address <= adr;
    avl_req.read <= ~wr;
    avl_req.write <= wr;
    avl_req.writedata <= wd;
    avl_req.byteenable <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (avl_rsp.waitrequest !== 1'b0 && n < 50);
    rdat = avl_rsp.readdata;
    `CHK("bus answer", 1'b0, avl_rsp.waitrequest)
    avl_req.read <= 1'b0;
    avl_req.write <= 1'b0;
    @(posedge mclk);
  endtask

  // Register write, all byte lanes enabled.
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus_xfer(1'b1, adr, wd, dummy);
  endtask

  // Register read compared with an expected value.
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] ex, input string nm);
    bus_xfer(1'b0, adr, 32'h0000_0000, rd);
    `CHK(nm, ex, rd)
  endtask

  // Lets a comparator change cross the synchroniser and sense logic.
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask

  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    fails = 0;
    check_count = 0;
    rst_b = 1'b0;
    avl_req = '0;
    cmp_raw = 3'b000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    // Reset values and an unmapped place.
    `CHK("irq at reset", 1'b0, irq)
    `CHK("total at reset", 6'h20, ladder_total)
    rd_chk(`OFS_IRQ_ENABLE, 32'h0000_0000, "enable reset");
    rd_chk(`OFS_LADDER_CTRL, 32'h0000_0000, "ladder reset");
    rd_chk(`OFS_MASKED_STATUS, 32'h0000_0000, "masked reset");
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'(32 * i + 36), 32'h0000_0000, "control reset");
      rd_chk(8'(32 * i + 32), 32'h0000_0000, "status reset");
    end
    wr(8'h0C, 32'h0000_0007);
    rd_chk(8'h0C, 32'h0000_0000, "unmapped");
    wr(`OFS_IRQ_ENABLE, 32'h0000_0005);
    rd_chk(`OFS_IRQ_ENABLE, 32'h0000_0005, "enable rw");
    wr(`OFS_IRQ_ENABLE, 32'h0000_0000);
    // Ladder power, range and tap.
    wr(`OFS_LADDER_CTRL, 32'h0000_030C);
    `CHK("ladder cfg", 6'h3C, 6'(ladder_cfg))
    `CHK("ladder total", 6'h18, ladder_total)
    `CHK("tap", 4'hC, ladder_tap_eff)
    rd_chk(`OFS_LADDER_CTRL, 32'h0000_030C, "ladder rw");
    wr(`OFS_LADDER_CTRL, 32'h0000_000C);
    `CHK("tap unpowered", 4'h0, ladder_tap_eff)
    `CHK("ladder total wide", 6'h20, ladder_total)
    wr(`OFS_LADDER_CTRL, 32'h0000_0205);
    `CHK("tap powered", 4'h5, ladder_tap_eff)
    // Positive source of every comparator, every defined code; sense quiet.
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 3; s++) begin
        wr(8'(32 * i + 36), (32'(s) << 9) | 32'h0000_000C);
        `CHK("source", 2'(s), positive_source_select[2*i +: 2])
        rd_chk(8'(32 * i + 36), (32'(s) << 9) | 32'h0000_000C, "control rw");
      end
    end
    // Output value, then inverted.
    cmp_raw <= 3'b101;
    settle();
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'(32 * i + 32), {30'h0, cmp_raw[i], 1'b0}, "status");
      wr(8'(32 * i + 36), 32'h0000_000E);
      settle();
      rd_chk(8'(32 * i + 32), {30'h0, ~cmp_raw[i], 1'b0}, "status inverted");
    end
    for (int i = 0; i < 3; i++) wr(8'(32 * i + 36), 32'h0000_000C);
    wr(`OFS_RAW_STATUS, 32'h0000_0007);
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0000, "raw cleared");
    // Rising edge on comparator zero with interrupt disabled.
    cmp_raw <= 3'b000;
    wr(`OFS_CMP0_CONTROL, 32'h0000_0008);
    settle();
    cmp_raw <= 3'b001;
    settle();
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0001, "raw rise");
    rd_chk(`OFS_MASKED_STATUS, 32'h0000_0000, "masked off");
    `CHK("irq masked", 1'b0, irq)
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
    `CHK("irq enabled", 1'b1, irq)
    rd_chk(`OFS_MASKED_STATUS, 32'h0000_0001, "masked on");
    wr(`OFS_RAW_STATUS, 32'h0000_0001);
    settle();
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0000, "no retrigger");
    `CHK("irq cleared", 1'b0, irq)
    // Falling edge on comparator one.
    wr(`OFS_CMP1_CONTROL, 32'h0000_0004);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0002);
    cmp_raw <= 3'b011;
    settle();
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0000, "fall idle");
    cmp_raw <= 3'b001;
    settle();
    rd_chk(`OFS_MASKED_STATUS, 32'h0000_0002, "fall");
    `CHK("irq fall", 1'b1, irq)
    wr(`OFS_CMP1_CONTROL, 32'h0000_000C);
    wr(`OFS_RAW_STATUS, 32'h0000_0002);
    // Inverted rising sense sees a falling input on comparator zero.
    wr(`OFS_CMP0_CONTROL, 32'h0000_000A);
    settle();
    wr(`OFS_RAW_STATUS, 32'h0000_0001);
    cmp_raw <= 3'b000;
    settle();
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0001, "inverted edge");
    wr(`OFS_CMP0_CONTROL, 32'h0000_000C);
    wr(`OFS_RAW_STATUS, 32'h0000_0001);
    // Level sense high on comparator two holds its flag.
    wr(`OFS_CMP2_CONTROL, 32'h0000_0010);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0004);
    cmp_raw <= 3'b100;
    settle();
    wr(`OFS_RAW_STATUS, 32'h0000_0004);
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0004, "level holds");
    `CHK("irq level", 1'b1, irq)
    cmp_raw <= 3'b000;
    settle();
    wr(`OFS_RAW_STATUS, 32'h0000_0004);
    rd_chk(`OFS_RAW_STATUS, 32'h0000_0000, "level gone");
    // Level sense low fires on a low output.
    wr(`OFS_CMP2_CONTROL, 32'h0000_0000);
    settle();
    rd_chk(`OFS_MASKED_STATUS, 32'h0000_0004, "level low");
    wrap_up();
  end
endmodule // test_acmp_regs

// [verilog/acmp_params.svh]
/*
  Offsets, field positions, reset values and timing counts of the analog
  comparator register bank.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH

// Register byte offsets.
`define OFS_MASKED_STATUS    8'h00
`define OFS_RAW_STATUS       8'h04
`define OFS_IRQ_ENABLE       8'h08
`define OFS_LADDER_CTRL      8'h10
`define OFS_CMP0_STATUS      8'h20
`define OFS_CMP0_CONTROL     8'h24
`define OFS_CMP1_STATUS      8'h40
`define OFS_CMP1_CONTROL     8'h44
`define OFS_CMP2_STATUS      8'h60
`define OFS_CMP2_CONTROL     8'h64

// Field positions of the ladder reference control register.
`define LADDER_POWER_BIT     9
`define LADDER_RANGE_BIT     8
`define LADDER_TAP_HI        3
`define LADDER_TAP_LO        0

// Field positions of each comparator control register.
`define SRC_HI               10
`define SRC_LO               9
`define LEVEL_BIT            4
`define SENSE_HI             3
`define SENSE_LO             2
`define INVERT_BIT           1

// Output value bit of each comparator status register.
`define COMPARE_OUTPUT_VALUE_BIT             1

// Reset values.
`define RESET_ZERO32         32'h0000_0000
`define RESET_ZERO3          3'h0

// Sense field encodings.
`define SENSE_LEVEL          2'h0
`define SENSE_FALL           2'h1
`define SENSE_RISE           2'h2

// Positive source encodings.
`define SRC_OWN_PIN          2'h0
`define SRC_CMP0_PIN         2'h1
`define SRC_INTERNAL_REF     2'h2

// Ladder totals in resistor units, by range bit.
`define LADDER_TOTAL_WIDE    6'h20
`define LADDER_TOTAL_NARROW  6'h18

// Slave answers one cycle after it takes a request.
`define BUS_WAIT_CYCLES      1

`endif

// [verilog/acmp_pkg.sv]
/*
  Types shared by the analog comparator register bank.
  Assumes acmp_params.svh is on the include path.
*/
package acmp_pkg;
  `include "acmp_params.svh"

  // One Avalon-MM request from the master.
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avl_req_type;

  // Answer of the slave.
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avl_rsp_type;

  // Settings of one comparator.
  typedef struct packed {
    logic [1:0] source;
    logic       level;
    logic [1:0] sense;
    logic       invert;
  } cmp_cfg_type;

  // Settings of the resistor ladder.
  typedef struct packed {
    logic       power;
    logic       range;
    logic [3:0] tap;
  } ladder_cfg_type;

  // Bus slave states.
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;
endpackage

// [verilog/acmp_regs.sv]
/*
  Register bank of three analog comparators behind an Avalon-MM slave.
  Assumes comparator outputs are asynchronous digital levels and the
  analog ladder and multiplexers consume the configuration outputs.
*/
// Function
// - Enable bits 2,1,0 let comparators two, one, zero raise the interrupt.
// - Ladder power bit 9 powers the resistor ladder.
// - Tap field 3:0 picks the ladder tap used as reference.
// - Status registers at 0x20,0x40,0x60 return output value in bit 1.
// - Source field 10:9 picks own pin, comparator zero pin or reference.
// - Invert bit flips the output before all further processing.
// - Range bit picks a 32 or 24 unit ladder total.
// - Unpowered ladder puts the reference at ground whatever the tap.
// - Raw flag sets on the sense condition regardless of enable.
`timescale 1ns/1ps
`include "acmp_params.svh"
module acmp_regs (
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // Avalon-MM slave.
  input  wire acmp_pkg::avl_req_type avl_req,
  output acmp_pkg::avl_rsp_type      avl_rsp,
  // Comparator outputs from the analog macro.
  input  wire logic [2:0]            cmp_raw,
  // Analog configuration.
  output acmp_pkg::ladder_cfg_type   ladder_cfg,
  output logic [5:0]                 ladder_total,
  output logic [3:0]                 ladder_tap_eff,
  output logic [5:0]                 positive_source_select,
  // Interrupt.
  output logic                       irq
);
  import acmp_pkg::*;

  typedef struct packed {
    bus_state_type  bus;
    logic [31:0]    rdata;
    logic [2:0]     enable;
    ladder_cfg_type ladder;
    cmp_cfg_type    cfg0;
    cmp_cfg_type    cfg1;
    cmp_cfg_type    cfg2;
    logic [2:0]     raw;
    logic [2:0]     compare_output_value;
    logic           irq;
    logic [5:0]     total;
    logic [3:0]     tap_eff;
    logic [5:0]     src;
  } bank_state_type;

  bank_state_type s_q;
  bank_state_type s_d;
  logic [2:0]     value;
  logic [2:0]     hit;
  logic [2:0]     masked;
  logic           take;
  logic           wr;
  logic           clr;
  logic [31:0]    wdata;

  // One sense unit per comparator.
  cmp_sense u_sense0 (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .cmp_raw (cmp_raw[0]),
    .cfg     (s_q.cfg0),
    .value   (value[0]),
    .hit     (hit[0])
  );

  cmp_sense u_sense1 (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .cmp_raw (cmp_raw[1]),
    .cfg     (s_q.cfg1),
    .value   (value[1]),
    .hit     (hit[1])
  );

  cmp_sense u_sense2 (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .cmp_raw (cmp_raw[2]),
    .cfg     (s_q.cfg2),
    .value   (value[2]),
    .hit     (hit[2])
  );

  // Request taken in idle and answered in the next cycle; a write lands only at
  // the answer edge, where the master sees waitrequest low.
  assign take   = (s_q.bus == BUS_IDLE) && (avl_req.read || avl_req.write);
  assign wr     = (s_q.bus == BUS_ANSWER) && avl_req.write;
  assign wdata  = avl_req.writedata;
  assign masked = s_q.raw & s_q.enable;

  // Byte lane one and zero both carry control fields.
  function automatic cmp_cfg_type cfg_write(input cmp_cfg_type old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
    cmp_cfg_type c;
    c = old;
    if (be[1]) begin
      c.source = d[`SRC_HI:`SRC_LO];
    end
    if (be[0]) begin
      c.level  = d[`LEVEL_BIT];
      c.sense  = d[`SENSE_HI:`SENSE_LO];
      c.invert = d[`INVERT_BIT];
    end
    return c;
  endfunction

  function automatic logic [31:0] cfg_read(input cmp_cfg_type c);
    logic [31:0] r;
    r = `RESET_ZERO32;
    r[`SRC_HI:`SRC_LO]     = c.source;
    r[`LEVEL_BIT]          = c.level;
    r[`SENSE_HI:`SENSE_LO] = c.sense;
    r[`INVERT_BIT]         = c.invert;
    return r;
  endfunction

  // Next state of the whole bank.
  always_comb begin
    s_d     = s_q;
    clr     = 1'b0;
    s_d.compare_output_value = value;
    // Bus handshake.
    case (s_q.bus)
      BUS_IDLE: begin
        if (take) begin
          s_d.bus = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        s_d.bus = BUS_IDLE;
      end
      default: begin
        s_d.bus = BUS_IDLE;
      end
    endcase
    // Read data captured when the request is taken; reserved bits read zero.
    s_d.rdata = `RESET_ZERO32;
    if (take && avl_req.read) begin
      case (avl_req.address)
        `OFS_MASKED_STATUS: s_d.rdata[2:0] = masked;
        `OFS_RAW_STATUS:    s_d.rdata[2:0] = s_q.raw;
        `OFS_IRQ_ENABLE:    s_d.rdata[2:0] = s_q.enable;
        `OFS_LADDER_CTRL: begin
          s_d.rdata[`LADDER_POWER_BIT]             = s_q.ladder.power;
          s_d.rdata[`LADDER_RANGE_BIT]             = s_q.ladder.range;
          s_d.rdata[`LADDER_TAP_HI:`LADDER_TAP_LO] = s_q.ladder.tap;
        end
        `OFS_CMP0_STATUS:   s_d.rdata[`COMPARE_OUTPUT_VALUE_BIT] = s_q.compare_output_value[0];
        `OFS_CMP1_STATUS:   s_d.rdata[`COMPARE_OUTPUT_VALUE_BIT] = s_q.compare_output_value[1];
        `OFS_CMP2_STATUS:   s_d.rdata[`COMPARE_OUTPUT_VALUE_BIT] = s_q.compare_output_value[2];
        `OFS_CMP0_CONTROL:  s_d.rdata = cfg_read(s_q.cfg0);
        `OFS_CMP1_CONTROL:  s_d.rdata = cfg_read(s_q.cfg1);
        `OFS_CMP2_CONTROL:  s_d.rdata = cfg_read(s_q.cfg2);
        default:            s_d.rdata = `RESET_ZERO32;
      endcase
    end
    // Register writes; raw status clears flags, other status offsets and unmapped writes are ignored.
    if (wr) begin
      case (avl_req.address)
        `OFS_RAW_STATUS: begin
          clr = avl_req.byteenable[0];
        end
        `OFS_IRQ_ENABLE: begin
          if (avl_req.byteenable[0]) begin
            s_d.enable = wdata[2:0];
          end
        end
        `OFS_LADDER_CTRL: begin
          if (avl_req.byteenable[1]) begin
            s_d.ladder.power = wdata[`LADDER_POWER_BIT];
            s_d.ladder.range = wdata[`LADDER_RANGE_BIT];
          end
          if (avl_req.byteenable[0]) begin
            s_d.ladder.tap = wdata[`LADDER_TAP_HI:`LADDER_TAP_LO];
          end
        end
        `OFS_CMP0_CONTROL: s_d.cfg0 = cfg_write(s_q.cfg0, wdata, avl_req.byteenable);
        `OFS_CMP1_CONTROL: s_d.cfg1 = cfg_write(s_q.cfg1, wdata, avl_req.byteenable);
        `OFS_CMP2_CONTROL: s_d.cfg2 = cfg_write(s_q.cfg2, wdata, avl_req.byteenable);
        default: begin
        end
      endcase
    end
    // Sticky raw flags: write one to clear, a new hit wins over the clear.
    s_d.raw = (s_q.raw & ~(clr ? wdata[2:0] : 3'h0)) | hit;
    s_d.irq = |(s_d.raw & s_d.enable);
    // Ladder outputs: ground when unpowered, total from the range bit.
    s_d.total   = s_d.ladder.range ? `LADDER_TOTAL_NARROW
                                   : `LADDER_TOTAL_WIDE;
    s_d.tap_eff = s_d.ladder.power ? s_d.ladder.tap : 4'h0;
    s_d.src     = {s_d.cfg2.source, s_d.cfg1.source, s_d.cfg0.source};
  end

  // Register the whole bank.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.bus   <= BUS_IDLE;
      s_q.total <= `LADDER_TOTAL_WIDE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  assign avl_rsp.readdata    = s_q.rdata;
  assign avl_rsp.waitrequest = s_q.bus[0];   // One-hot idle flop doubles as the wait flag.
  assign ladder_cfg          = s_q.ladder;
  assign ladder_total        = s_q.total;
  assign ladder_tap_eff      = s_q.tap_eff;
  assign positive_source_select = s_q.src;
  assign irq                 = s_q.irq;

  chk_irq_masked: assert property (@(posedge mclk) disable iff (!rst_b)
    irq == |($past(s_d.raw) & s_q.enable))
    else $error("Interrupt does not follow masked flags.");

  chk_raw_sets: assert property (@(posedge mclk) disable iff (!rst_b)
    |hit |=> |s_q.raw)
    else $error("Raw flag not set on hit.");

  chk_raw_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    (s_q.raw[0] && !clr) |=> s_q.raw[0])
    else $error("Raw flag lost without clear.");

  chk_enable_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_IRQ_ENABLE && avl_req.byteenable[0])
      |=> s_q.enable == $past(wdata[2:0]))
    else $error("Enable write not stored.");

  chk_ladder_ground: assert property (@(posedge mclk) disable iff (!rst_b)
    !ladder_cfg.power |-> ladder_tap_eff == 4'h0)
    else $error("Reference not grounded when unpowered.");

  chk_ladder_tap: assert property (@(posedge mclk) disable iff (!rst_b)
    ladder_cfg.power |-> ladder_tap_eff == ladder_cfg.tap)
    else $error("Tap not passed to reference.");

  chk_ladder_range: assert property (@(posedge mclk) disable iff (!rst_b)
    ladder_total == (ladder_cfg.range ? 6'h18 : 6'h20))
    else $error("Ladder total wrong for range.");

  chk_status_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_CMP1_STATUS)
      |=> !avl_rsp.waitrequest && avl_rsp.readdata == {30'h0, $past(s_q.compare_output_value[1]), 1'b0})
    else $error("Status read wrong.");

  chk_bus_answer: assert property (@(posedge mclk) disable iff (!rst_b)
    take |=> !avl_rsp.waitrequest ##1 avl_rsp.waitrequest)
    else $error("Bus answer not one cycle.");

  chk_power_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_LADDER_CTRL && avl_req.byteenable[1])
      |=> ladder_cfg.power == $past(wdata[9]))
    else $error("Ladder power not stored.");

  // Read paths: each read returns what the bank held at the taking edge.
  chk_enable_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_IRQ_ENABLE)
      |=> avl_rsp.readdata == {29'h0, $past(s_q.enable)})
    else $error("Enable read wrong.");

  chk_raw_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_RAW_STATUS)
      |=> avl_rsp.readdata == {29'h0, $past(s_q.raw)})
    else $error("Raw status read wrong.");

  chk_masked_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_MASKED_STATUS)
      |=> avl_rsp.readdata == {29'h0, $past(masked)})
    else $error("Masked status read wrong.");

  chk_ladder_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_LADDER_CTRL)
      |=> avl_rsp.readdata[`LADDER_POWER_BIT] == $past(s_q.ladder.power))
    else $error("Ladder power read wrong.");

  chk_control_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (take && avl_req.read && avl_req.address == `OFS_CMP2_CONTROL)
      |=> avl_rsp.readdata[`SRC_HI:`SRC_LO] == $past(s_q.cfg2.source))
    else $error("Source field read wrong.");

  chk_wait_data: assert property (@(posedge mclk) disable iff (!rst_b)
    avl_rsp.waitrequest |-> avl_rsp.readdata == 32'h0000_0000)
    else $error("Read data not zero while waiting.");

  // Write paths: fields land from the held request at the answer edge only.
  chk_idle_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (s_q.bus == BUS_IDLE) |=> $stable(s_q.enable))
    else $error("Write landed before the answer edge.");

  chk_range_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_LADDER_CTRL && avl_req.byteenable[1])
      |=> ladder_cfg.range == $past(wdata[`LADDER_RANGE_BIT]))
    else $error("Ladder range not stored.");

  chk_tap_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_LADDER_CTRL && avl_req.byteenable[0])
      |=> ladder_cfg.tap == $past(wdata[`LADDER_TAP_HI:`LADDER_TAP_LO]))
    else $error("Ladder tap not stored.");

  chk_sense_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_CMP0_CONTROL && avl_req.byteenable[0])
      |=> s_q.cfg0.sense == $past(wdata[`SENSE_HI:`SENSE_LO]))
    else $error("Sense field not stored.");

  chk_invert_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_CMP1_CONTROL && avl_req.byteenable[0])
      |=> s_q.cfg1.invert == $past(wdata[`INVERT_BIT]))
    else $error("Invert bit not stored.");

  chk_level_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_CMP2_CONTROL && avl_req.byteenable[0])
      |=> s_q.cfg2.level == $past(wdata[`LEVEL_BIT]))
    else $error("Level bit not stored.");

  chk_source_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_CMP2_CONTROL && avl_req.byteenable[1])
      |=> s_q.cfg2.source == $past(wdata[`SRC_HI:`SRC_LO]))
    else $error("Source field not stored.");

  chk_source_out: assert property (@(posedge mclk) disable iff (!rst_b)
    positive_source_select == {s_q.cfg2.source, s_q.cfg1.source, s_q.cfg0.source})
    else $error("Source select output wrong.");

  // Sticky flags: a written one clears, a new hit in the same cycle wins.
  chk_raw_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && avl_req.address == `OFS_RAW_STATUS && avl_req.byteenable[0] && wdata[0] && !hit[0])
      |=> !s_q.raw[0])
    else $error("Raw flag not cleared.");

  chk_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    (clr && hit[2]) |=> s_q.raw[2])
    else $error("Clear beat a new hit.");
endmodule // acmp_regs

// [verilog/cmp_sense.sv]
/*
  Sense logic for one comparator: synchroniser, inversion and interrupt
  condition detection.
  Assumes the raw comparator output is asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "acmp_params.svh"
module cmp_sense (
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Comparator and configuration.
  input  wire logic                 cmp_raw,
  input  wire acmp_pkg::cmp_cfg_type cfg,
  // Results.
  output logic                      value,
  output logic                      hit
);
  import acmp_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic prev;
  } sense_state_type;

  sense_state_type s_q;
  sense_state_type s_d;

  // Two-flop synchroniser, then inversion, then a one-cycle history.
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = cmp_raw;
    s_d.sync2 = s_q.sync1;
    s_d.out   = s_q.sync2 ^ cfg.invert;
    s_d.prev  = s_q.out;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Selected sense condition on the processed output.
  always_comb begin
    case (cfg.sense)
      `SENSE_LEVEL: hit = (s_q.out == cfg.level);
      `SENSE_FALL:  hit = s_q.prev & ~s_q.out;
      `SENSE_RISE:  hit = ~s_q.prev & s_q.out;
      default:      hit = 1'b0;
    endcase
  end

  assign value = s_q.out;

  chk_edge_rise: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg.sense == `SENSE_RISE && $rose(value) && $stable(cfg)) |-> hit)
    else $error("Rising edge not sensed.");

  chk_invert_path: assert property (@(posedge mclk) disable iff (!rst_b)
    $stable(cfg.invert) |-> value == ($past(s_q.sync2) ^ cfg.invert))
    else $error("Inversion not applied.");
endmodule // cmp_sense
